// file: logic/vii_params.svh
`ifndef VII_PARAMS_SVH
`define VII_PARAMS_SVH
// =====================================================================
// Timing
`define VII_CLK_MHZ 50
`define VII_DTACK_DLY_NS 500
`define VII_DTACK_DLY_CYC ((`VII_DTACK_DLY_NS * `VII_CLK_MHZ + 999) / 1000)
`define VII_DEB_BASE_NS 7000
`define VII_DEB_BASE_CYC ((`VII_DEB_BASE_NS * `VII_CLK_MHZ + 999) / 1000)
`define VII_BUS_TMO_NS 64000
`define VII_BUS_TMO_CYC ((`VII_BUS_TMO_NS * `VII_CLK_MHZ) / 1000)
// =====================================================================
// Register byte offsets inside the board window
`define VII_OFF_BSR 8'h81
`define VII_OFF_STAT 8'hC1
`define VII_OFF_EN 8'hC3
`define VII_OFF_POL 8'hC5
`define VII_OFF_TYP 8'hC7
`define VII_OFF_PEN 8'hC9
`define VII_OFF_DIN 8'hCA
`define VII_OFF_VEC_HI 4'hD
// =====================================================================
// Fields and codes
`define VII_BSR_GIE 3
`define VII_PAT_CH 7
`define VII_AM_SHORT_SUP 6'h2D
`define VII_AM_SHORT_USR 6'h29
// =====================================================================
// Sampled bus vector layout in the device
`define VII_BV_AS 0
`define VII_BV_DS0 1
`define VII_BV_DS1 2
`define VII_BV_WR 3
`define VII_BV_IACK 4
`define VII_BV_IACKIN 5
`define VII_BV_AM 6
`define VII_BV_A 12
`define VII_BV_D 27
`define VII_BV_DEB 43
`define VII_BV_W 45
`endif

// file: logic/vii_pkg.sv
`include "vii_params.svh"
package vii_pkg;
  typedef logic [7:0] vii_byte_t;
  typedef logic [15:0] vii_word_t;
  typedef enum logic [2:0] {
    VII_D_IDLE = 3'b000,
    VII_D_WAIT = 3'b001,
    VII_D_ACK = 3'b010,
    VII_D_PASS = 3'b011,
    VII_D_SKIP = 3'b100
  } vii_dst_e;
  typedef enum logic [1:0] {
    VII_H_IDLE = 2'b00,
    VII_H_ADDR = 2'b01,
    VII_H_STRB = 2'b10,
    VII_H_REL = 2'b11
  } vii_hst_e;
  typedef struct packed {
    logic s1;
    logic s2;
    logic lvl;
    logic chg;
    logic [15:0] cnt;
  } vii_chan_s;
  typedef struct packed {
    logic [`VII_BV_W-1:0] s1;
    logic [`VII_BV_W-1:0] s2;
    vii_dst_e st;
    logic [7:0] cnt;
    logic gie;
    logic [1:0] bst;
    vii_byte_t en;
    vii_byte_t pol;
    vii_byte_t typ;
    vii_byte_t pen;
    vii_byte_t pend;
    logic [7:0][7:0] older;
    logic [7:0][7:0] vec;
    vii_word_t rd;
    logic d_oe;
    logic dtack;
    logic iackout_n;
    logic irq;
  } vii_dev_s;
  typedef struct packed {
    vii_hst_e st;
    logic [11:0] cnt;
    logic [17:0] s1;
    logic [17:0] s2;
    logic [5:0] am;
    logic [15:1] a;
    vii_word_t wd;
    logic d_oe;
    logic as_n;
    logic ds_n;
    logic write_n;
    logic iack_n;
    logic iackin_n;
    vii_word_t rd;
    logic tmo;
    logic busy;
    logic done;
    logic err;
    logic irq;
  } vii_host_s;
endpackage : vii_pkg

// file: logic/vii_if.sv
`timescale 1ns/10ps
interface vii_if;
  logic [5:0] am;
  logic [15:1] addr;
  logic as_n;
  logic ds0_n;
  logic ds1_n;
  logic write_n;
  logic iack_n;
  logic iackin_n;
  logic iackout_n;
  logic [15:0] hd_out;
  logic hd_oe;
  logic [15:0] dd_out;
  logic dd_oe;
  logic dtack_out;
  logic dtack_oe;
  logic irq_out;
  logic irq_oe;
  logic [15:0] data;
  logic dtack_n;
  logic irq_n;
  // Resolved wire levels; undriven lines float high
  assign data = dd_oe ? dd_out : (hd_oe ? hd_out : 16'hFFFF);
  assign dtack_n = !(dtack_oe && !dtack_out);
  assign irq_n = !(irq_oe && !irq_out);
  modport dev (
    input am, addr, as_n, ds0_n, ds1_n, write_n, iack_n, iackin_n, data,
    output iackout_n, dd_out, dd_oe, dtack_out, dtack_oe, irq_out, irq_oe
  );
  modport host (
    output am, addr, as_n, ds0_n, ds1_n, write_n, iack_n, iackin_n, hd_out, hd_oe,
    input data, dtack_n, irq_n
  );
endinterface : vii_if

// file: logic/vii_chan.sv
`timescale 1ns/10ps
module vii_chan (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Raw input and shared debounce length
  input wire logic raw_in,
  input wire logic [15:0] lim_in,
  // Debounced level and change pulse
  output logic lvl_out,
  output logic chg_out
);
  import vii_pkg::*;
  vii_chan_s r;
  vii_chan_s n;

  always_comb begin
    n = r;
    n.s1 = raw_in;
    n.s2 = r.s1;
    n.chg = 1'b0;
    if (r.s2 == r.lvl) begin
      n.cnt = 16'h0000;
    end else if (r.cnt >= lim_in) begin
      n.lvl = r.s2;
      n.chg = 1'b1;
      n.cnt = 16'h0000;
    end else begin
      n.cnt = r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign lvl_out = r.lvl;
  assign chg_out = r.chg;
endmodule : vii_chan

// file: logic/vii_device.sv
`timescale 1ns/10ps
`include "vii_params.svh"
// Functional notes
// R1 - Type zero: interrupt on polarity level match
// R2 - Host sets channel 7 vector for patterns
// R3 - Pattern match reported as channel 7 pending
// R4 - Global enable bit 3 gates request
// R5 - Writing one clears pending; zero keeps
// R6 - Only channels 0-7 interrupt, selectable kind
// R7 - Level mismatch on acknowledge: pass onward
// R8 - Level match: vector on D7-D0, acknowledge
// R9 - Request held until software clears pending
// R10 - Arrival order; ties favour higher channel
// R11 - Separate programmable vector per channel
// R12 - Persistent level re-raises after clear
// R13 - Request stays while other channels pending
// R14 - Request drops when nothing is pending
// R15 - Transfer acknowledge after fixed decode delay
// R16 - Never bus error; undecoded gets silence
// R17 - Handler disables, clears, re-enables channel
// R18 - Handler acknowledges with level on A3-A1
// R19 - One debounce setting for all channels
// R20 - Type one: interrupt on change of state
// R21 - Pattern fires when all enabled match
// R22 - Pending latches only while channel enabled; the pattern sets channel 7 pending without its enable bit
// R23 - Pending sticks until written one
module vii_device #(
  parameter logic [7:0] BASE = 8'h00,
  parameter logic [2:0] IRQ_LEVEL = 3'h3,
  parameter int DEB_BASE_CYC = `VII_DEB_BASE_CYC
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // System bus
  vii_if.dev BUS,
  // Field inputs and debounce selection
  input wire logic [7:0] DIN_IN,
  input wire logic [1:0] DEB_SEL_IN,
  // Status
  output vii_pkg::vii_byte_t PEND_OUT,
  output logic IRQ_OUT
);
  import vii_pkg::*;

  localparam logic [7:0] DLY = 8'(`VII_DTACK_DLY_CYC);
  // Synchronisers start at the idle bus level so no false cycle follows reset
  localparam vii_dev_s RST = '{st: VII_D_IDLE, s1: '1, s2: '1, iackout_n: 1'b1, default: '0};

  vii_dev_s r;
  vii_dev_s n;
  logic [7:0] lvl;
  logic [7:0] chg;
  logic [7:0] cond;
  logic [7:0] setv;
  logic [7:0] clr;
  logic [7:0] pc;
  logic [7:0] newv;
  logic [15:0] lim;
  logic [15:1] a;
  logic [7:0] a8;
  logic [15:0] d;
  logic [15:0] rdv;
  logic [5:0] am;
  logic [2:0] sel;
  logic as_a;
  logic ds_a;
  logic ds0_a;
  logic wr;
  logic iack;
  logic iackin;
  logic am_ok;
  logic hit;
  logic dec;

  // Oldest pending channel; ties were ordered when they arrived
  function automatic logic [2:0] vii_oldest(input logic [7:0] p, input logic [7:0][7:0] o);
    logic [2:0] res;
    res = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (p[i] && ((o[i] & p) == 8'h00)) begin
        res = 3'(i);
      end
    end
    return res;
  endfunction : vii_oldest

  // =====================================================================
  // Input channels
  assign lim = 16'(DEB_BASE_CYC) << {r.s2[`VII_BV_DEB+1:`VII_BV_DEB], 1'b0}; // R19

  for (genvar i = 0; i < 8; i++) begin : g_ch
    vii_chan u_ch (
      .clk_in(CLK_IN),
      .resetn_in(RESETN_IN),
      .raw_in(DIN_IN[i]),
      .lim_in(lim),
      .lvl_out(lvl[i]),
      .chg_out(chg[i])
    );
  end

  // =====================================================================
  // Bus decode
  assign as_a = !r.s2[`VII_BV_AS];
  assign ds0_a = !r.s2[`VII_BV_DS0];
  assign ds_a = ds0_a || !r.s2[`VII_BV_DS1];
  assign wr = !r.s2[`VII_BV_WR];
  assign iack = !r.s2[`VII_BV_IACK];
  assign iackin = !r.s2[`VII_BV_IACKIN];
  assign am = r.s2[`VII_BV_AM+5:`VII_BV_AM];
  assign a = r.s2[`VII_BV_A+14:`VII_BV_A];
  assign d = r.s2[`VII_BV_D+15:`VII_BV_D];
  assign a8 = {a[7:1], 1'b1};
  assign am_ok = (am == `VII_AM_SHORT_SUP) || (am == `VII_AM_SHORT_USR);
  assign hit = (a8 == `VII_OFF_BSR) || (a8 == `VII_OFF_STAT) || (a8 == `VII_OFF_EN) ||
               (a8 == `VII_OFF_POL) || (a8 == `VII_OFF_TYP) || (a8 == `VII_OFF_PEN) ||
               (a8 == (`VII_OFF_DIN | 8'h01)) || (a8[7:4] == `VII_OFF_VEC_HI);
  assign dec = am_ok && (a[15:8] == BASE) && hit;
  assign sel = vii_oldest(r.pend, r.older); // R10

  // =====================================================================
  // Next state
  always_comb begin
    n = r;
    n.s1 = {DEB_SEL_IN, BUS.data, BUS.addr, BUS.am, BUS.iackin_n, BUS.iack_n,
            BUS.write_n, BUS.ds1_n, BUS.ds0_n, BUS.as_n};
    n.s2 = r.s1;
    clr = 8'h00;
    rdv = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      cond[i] = r.typ[i] ? chg[i] : (lvl[i] == r.pol[i]); // R1 R20 R12
    end
    setv = r.en & cond; // R6 R22
    if (r.gie && (r.pen != 8'h00) && (((lvl ~^ r.pol) & r.pen) == r.pen)) begin
      setv[`VII_PAT_CH] = 1'b1; // R21 R3
    end
    // Read data
    if (a8[7:4] == `VII_OFF_VEC_HI) begin
      rdv = {8'h00, r.vec[a8[3:1]]};
    end else begin
      case (a8)
        `VII_OFF_BSR: rdv = {12'h000, r.gie, 1'b0, r.bst};
        `VII_OFF_STAT: rdv = {8'h00, r.pend};
        `VII_OFF_EN: rdv = {8'h00, r.en};
        `VII_OFF_POL: rdv = {8'h00, r.pol};
        `VII_OFF_TYP: rdv = {8'h00, r.typ};
        `VII_OFF_PEN: rdv = {8'h00, r.pen};
        (`VII_OFF_DIN | 8'h01): rdv = {8'h00, lvl};
        default: rdv = 16'h0000;
      endcase
    end
    // Bus cycle
    case (r.st)
      VII_D_IDLE: begin
        n.cnt = 8'h00;
        if (as_a && ds_a) begin
          if (iack) begin
            if (iackin) begin
              if (r.irq && (a[3:1] == IRQ_LEVEL)) begin
                n.st = VII_D_WAIT; // R8
              end else begin
                n.st = VII_D_PASS; // R7
                n.iackout_n = 1'b0;
              end
            end
          end else begin
            n.st = dec ? VII_D_WAIT : VII_D_SKIP; // R16
          end
        end
      end
      VII_D_WAIT: begin
        n.cnt = r.cnt + 8'h01;
        if (r.cnt == DLY - 8'h01) begin
          n.st = VII_D_ACK;
          n.dtack = 1'b1; // R15
          if (iack) begin
            n.rd = {8'h00, r.vec[sel]}; // R8 R11
            n.d_oe = 1'b1;
          end else if (!wr) begin
            n.rd = rdv;
            n.d_oe = 1'b1;
          end else if (ds0_a) begin
            if (a8[7:4] == `VII_OFF_VEC_HI) begin
              n.vec[a8[3:1]] = d[7:0]; // R11
            end else begin
              case (a8)
                `VII_OFF_BSR: begin
                  n.gie = d[`VII_BSR_GIE]; // R4
                  n.bst = d[1:0];
                end
                `VII_OFF_STAT: clr = d[7:0]; // R5
                `VII_OFF_EN: n.en = d[7:0];
                `VII_OFF_POL: n.pol = d[7:0];
                `VII_OFF_TYP: n.typ = d[7:0];
                `VII_OFF_PEN: n.pen = d[7:0];
                default: n.rd = r.rd;
              endcase
            end
          end
        end
      end
      VII_D_ACK: begin
        if (!ds_a) begin
          n.st = VII_D_IDLE;
          n.dtack = 1'b0;
          n.d_oe = 1'b0;
        end
      end
      VII_D_PASS: begin
        if (!as_a) begin
          n.st = VII_D_IDLE;
          n.iackout_n = 1'b1;
        end
      end
      VII_D_SKIP: begin
        if (!as_a) begin
          n.st = VII_D_IDLE;
        end
      end
      default: n.st = VII_D_IDLE;
    endcase
    // Pending bits: a new event beats a clear in the same cycle
    pc = r.pend & ~clr; // R5
    newv = setv & ~pc;
    n.pend = pc | setv; // R23
    for (int i = 0; i < 8; i++) begin
      if (newv[i]) begin
        n.older[i] = (pc & ~newv) | (newv & 8'(8'hFE << i)); // R10
      end else begin
        n.older[i] = r.older[i] & ~newv;
      end
    end
    n.irq = n.gie && (n.pend != 8'h00); // R4 R9 R13 R14
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  // =====================================================================
  // Outputs
  assign BUS.dd_out = r.rd;
  assign BUS.dd_oe = r.d_oe;
  assign BUS.dtack_out = 1'b0;
  assign BUS.dtack_oe = r.dtack;
  assign BUS.irq_out = 1'b0;
  assign BUS.irq_oe = r.irq;
  assign BUS.iackout_n = r.iackout_n;
  assign PEND_OUT = r.pend;
  assign IRQ_OUT = r.irq;
endmodule : vii_device

// file: logic/vii_host.sv
`timescale 1ns/10ps
`include "vii_params.svh"
module vii_host #(
  parameter int TMO_CYC = `VII_BUS_TMO_CYC
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // System bus
  vii_if.host BUS,
  // Command port
  input wire logic REQ_IN,
  input wire logic WRITE_IN,
  input wire logic IACK_IN,
  input wire logic [15:1] ADDR_IN,
  input wire logic [5:0] AM_IN,
  input wire logic [2:0] LEVEL_IN,
  input vii_pkg::vii_word_t WDATA_IN,
  // Answer
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output logic ERR_OUT,
  output vii_pkg::vii_word_t RDATA_OUT,
  output logic IRQ_OUT
);
  import vii_pkg::*;

  // Synchronisers start at the released line level: no false acknowledge or request
  localparam vii_host_s RST = '{st: VII_H_IDLE, s1: '1, s2: '1, as_n: 1'b1, ds_n: 1'b1,
                                write_n: 1'b1, iack_n: 1'b1, iackin_n: 1'b1, default: '0};

  vii_host_s r;
  vii_host_s n;
  logic dt;

  assign dt = !r.s2[1];

  always_comb begin
    n = r;
    n.s1 = {BUS.data, BUS.dtack_n, BUS.irq_n};
    n.s2 = r.s1;
    n.done = 1'b0;
    n.err = 1'b0;
    n.irq = !r.s2[0];
    case (r.st)
      VII_H_IDLE: begin
        n.cnt = 12'h000;
        if (REQ_IN) begin
          n.st = VII_H_ADDR;
          n.am = AM_IN;
          n.iack_n = !IACK_IN;
          n.a = IACK_IN ? {12'h000, LEVEL_IN} : ADDR_IN; // R18
          n.write_n = !(WRITE_IN && !IACK_IN);
          n.d_oe = WRITE_IN && !IACK_IN;
          n.wd = WDATA_IN;
        end
      end
      VII_H_ADDR: begin
        n.as_n = 1'b0;
        n.st = VII_H_STRB;
      end
      VII_H_STRB: begin
        n.ds_n = 1'b0;
        n.iackin_n = r.iack_n; // R18
        n.cnt = r.cnt + 12'h001;
        if (dt) begin
          n.rd = r.s2[17:2];
          n.st = VII_H_REL;
        end else if (r.cnt == 12'(TMO_CYC - 1)) begin
          n.tmo = 1'b1; // R16
          n.st = VII_H_REL;
        end
      end
      VII_H_REL: begin
        n.as_n = 1'b1;
        n.ds_n = 1'b1;
        n.iack_n = 1'b1;
        n.iackin_n = 1'b1;
        n.write_n = 1'b1;
        n.d_oe = 1'b0;
        if (!dt) begin
          n.st = VII_H_IDLE;
          n.done = 1'b1;
          n.err = r.tmo;
          n.tmo = 1'b0;
        end
      end
      default: n.st = VII_H_IDLE;
    endcase
    n.busy = n.st != VII_H_IDLE;
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  // =====================================================================
  // Outputs
  assign BUS.am = r.am;
  assign BUS.addr = r.a;
  assign BUS.as_n = r.as_n;
  assign BUS.ds0_n = r.ds_n;
  assign BUS.ds1_n = r.ds_n;
  assign BUS.write_n = r.write_n;
  assign BUS.iack_n = r.iack_n;
  assign BUS.iackin_n = r.iackin_n;
  assign BUS.hd_out = r.wd;
  assign BUS.hd_oe = r.d_oe;
  assign BUSY_OUT = r.busy;
  assign DONE_OUT = r.done;
  assign ERR_OUT = r.err;
  assign RDATA_OUT = r.rd;
  assign IRQ_OUT = r.irq;
endmodule : vii_host

// file: test/vii_props.sv
`timescale 1ns/10ps
module vii_props #(
  parameter logic [2:0] IRQ_LEVEL = 3'h3
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // Host driven bus signals
  input wire logic [5:0] am,
  input wire logic [15:1] addr,
  input wire logic as_n,
  input wire logic ds0_n,
  input wire logic ds1_n,
  input wire logic write_n,
  input wire logic iack_n,
  // Device driven bus signals
  input wire logic iackout_n,
  input wire logic [15:0] dd_out,
  input wire logic dd_oe,
  input wire logic dtack_oe,
  input wire logic irq_oe
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  logic [7:0] ds_cnt_r;
  logic [7:0] wr_age_r;
  // =====================================================
  // Strobe length and age of the last register write
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ds_cnt_r <= 8'h00;
      wr_age_r <= 8'hFF;
    end else begin
      ds_cnt_r <= ds0_n ? 8'h00 : ds_cnt_r + {7'h00, ds_cnt_r != 8'hFF};
      wr_age_r <= (!as_n && !write_n && iack_n) ? 8'h00 : wr_age_r + {7'h00, wr_age_r != 8'hFF};
    end
  end
  // =====================================================
  // Properties
  a_dtack_delay: assert property ($rose(dtack_oe) |-> ds_cnt_r inside {[8'h1A:8'h1E]})
    else $error("transfer acknowledge delay off");
  a_dtack_strobed: assert property ($rose(dtack_oe) |-> !as_n && !ds0_n && !ds1_n)
    else $error("acknowledge without strobes");
  a_dtack_holds: assert property (dtack_oe && !ds0_n && !ds1_n |=> dtack_oe)
    else $error("acknowledge dropped early");
  a_no_undecoded: assert property (!as_n && iack_n && !(am inside {6'h29, 6'h2D}) |-> !dtack_oe)
    else $error("answer to undecoded access");
  a_pass_mismatch: assert property ($fell(iackout_n) |-> !iack_n && (addr[3:1] != IRQ_LEVEL || !irq_oe))
    else $error("acknowledge passed on wrongly");
  a_pass_stands: assert property (!iackout_n && !as_n |=> !iackout_n)
    else $error("pass on released early");
  a_vector_match: assert property ($rose(dtack_oe) && !iack_n |-> iackout_n && addr[3:1] == IRQ_LEVEL && irq_oe && dd_oe)
    else $error("vector answer without level match");
  a_upper_zero: assert property (dd_oe |-> dd_out[15:8] == 8'h00)
    else $error("upper data byte not zero");
  a_read_data: assert property ($rose(dtack_oe) && write_n |-> dd_oe)
    else $error("read acknowledged without data");
  a_irq_held_ack: assert property (irq_oe && !iack_n |=> irq_oe)
    else $error("request dropped during acknowledge");
  a_irq_drop_write: assert property ($fell(irq_oe) |-> wr_age_r < 8'h28)
    else $error("request dropped without register write");
endmodule : vii_props

// file: test/vme_input_interrupter_bench.sv
`timescale 1ns/10ps
`include "vii_params.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin miscompares++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module vme_input_interrupter_bench;
  import vii_pkg::*;
  localparam logic [2:0] LVL = 3'h3;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic wr_c = 1'b0;
  logic ia_c = 1'b0;
  logic [15:1] addr_c = 15'h0000;
  logic [5:0] am_c = `VII_AM_SHORT_SUP;
  logic [2:0] lvl_c = 3'h0;
  vii_word_t wd_c = 16'h0000;
  logic [7:0] din = 8'h00;
  logic [1:0] deb_sel = 2'b00;
  logic [7:0] pend;
  logic dirq;
  logic busy;
  logic done;
  logic err;
  logic irq;
  vii_word_t rdat;
  logic [9:0] exp_q[$];
  logic [9:0] msk_q[$];
  logic [9:0] e;
  logic [9:0] m;
  logic [7:0] vec[8];
  logic [31:0] seed = 32'h0000003B;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  vii_if vii_if_inst();
  vii_device #(.IRQ_LEVEL(LVL), .DEB_BASE_CYC(2)) vii_device_inst (.CLK_IN(clk),
    .RESETN_IN(rst_n), .BUS(vii_if_inst), .DIN_IN(din), .DEB_SEL_IN(deb_sel), .PEND_OUT(pend),
    .IRQ_OUT(dirq));
  vii_host #(.TMO_CYC(60)) vii_host_inst (.CLK_IN(clk), .RESETN_IN(rst_n), .BUS(vii_if_inst),
    .REQ_IN(req), .WRITE_IN(wr_c), .IACK_IN(ia_c), .ADDR_IN(addr_c), .AM_IN(am_c),
    .LEVEL_IN(lvl_c), .WDATA_IN(wd_c), .BUSY_OUT(busy), .DONE_OUT(done), .ERR_OUT(err),
    .RDATA_OUT(rdat), .IRQ_OUT(irq));
  vii_props #(.IRQ_LEVEL(LVL)) vii_props_inst (.CLK_IN(clk), .RESETN_IN(rst_n),
    .am(vii_if_inst.am), .addr(vii_if_inst.addr), .as_n(vii_if_inst.as_n),
    .ds0_n(vii_if_inst.ds0_n), .ds1_n(vii_if_inst.ds1_n), .write_n(vii_if_inst.write_n),
    .iack_n(vii_if_inst.iack_n), .iackout_n(vii_if_inst.iackout_n),
    .dd_out(vii_if_inst.dd_out), .dd_oe(vii_if_inst.dd_oe),
    .dtack_oe(vii_if_inst.dtack_oe), .irq_oe(vii_if_inst.irq_oe));
  // =====================================================
  // Clock, watchdog and result monitor
  initial begin
    forever #10 clk = ~clk;
  end
  always @(negedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      tally_and_finish();
    end
    if (done === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      `CHK("irq err rdata", e & m, {irq, err, rdat[7:0]} & m)
    end
  end
  // =====================================================
  // Bus cycle tasks
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic xfer(input logic ia, input logic w, input logic [7:0] off,
    input logic [7:0] wd, input logic [9:0] ex, input logic [9:0] mk);
    int n;
    n = 0;
    @(negedge clk);
    exp_q.push_back(ex);
    msk_q.push_back(mk);
    {req, ia_c, wr_c, addr_c, wd_c} = {1'b1, ia, w, 8'h00, off[7:1], 8'h00, wd};
    @(negedge clk);
    req = 1'b0;
    `CHK("busy", 1'b1, busy)
    while (done !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n >= 300) begin
      miscompares++;
      tally_and_finish();
    end
  endtask : xfer
  task automatic rd(input logic [7:0] off, input logic i, input logic [7:0] v);
    xfer(1'b0, 1'b0, off, 8'h00, {i, 1'b0, v}, 10'h3FF);
  endtask : rd
  task automatic wr(input logic [7:0] off, input logic [7:0] v);
    xfer(1'b0, 1'b1, off, v, 10'h000, 10'h100);
  endtask : wr
  task automatic ack(input logic [2:0] l, input logic [9:0] ex, input logic [9:0] mk);
    lvl_c = l;
    xfer(1'b1, 1'b0, 8'h00, 8'h00, ex, mk);
  endtask : ack
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // =====================================================
  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    rd(`VII_OFF_BSR, 1'b0, 8'h00);
    rd(`VII_OFF_EN, 1'b0, 8'h00);
    am_c = 6'h3F;
    xfer(1'b0, 1'b0, `VII_OFF_STAT, 8'h00, 10'h100, 10'h100);
    am_c = `VII_AM_SHORT_SUP;
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      vec[k] = seed[7:0];
      wr(8'hD1 + 8'(2 * k), vec[k]);
    end
    am_c = `VII_AM_SHORT_USR;
    rd(8'hD7, 1'b0, vec[3]);
    am_c = `VII_AM_SHORT_SUP;
    $display("Test setup done");
    wr(`VII_OFF_TYP, 8'h00);
    wr(`VII_OFF_POL, 8'h05);
    wr(`VII_OFF_PEN, 8'h00);
    wr(`VII_OFF_EN, 8'h05);
    wr(`VII_OFF_STAT, 8'hFF);
    wr(`VII_OFF_BSR, 8'h08);
    rd(`VII_OFF_STAT, 1'b0, 8'h00);
    din[0] = 1'b1;
    repeat (12) @(negedge clk);
    din[2] = 1'b1;
    repeat (20) @(negedge clk);
    rd(`VII_OFF_STAT, 1'b1, 8'h05);
    `CHK("irq out", 1'b1, dirq);
    `CHK("pend out", 8'h05, pend);
    ack(LVL + 3'h1, 10'h100, 10'h100);
    ack(LVL, {2'b10, vec[0]}, 10'h3FF);
    wr(`VII_OFF_EN, 8'h04);
    wr(`VII_OFF_STAT, 8'h01);
    wr(`VII_OFF_EN, 8'h05);
    rd(`VII_OFF_STAT, 1'b1, 8'h05);
    ack(LVL, {2'b10, vec[2]}, 10'h3FF);
    din = 8'h00;
    repeat (20) @(negedge clk);
    wr(`VII_OFF_STAT, 8'h00);
    rd(`VII_OFF_STAT, 1'b1, 8'h05);
    wr(`VII_OFF_STAT, 8'h05);
    rd(`VII_OFF_STAT, 1'b0, 8'h00);
    `CHK("irq out", 1'b0, dirq);
    $display("Test level done");
    wr(`VII_OFF_EN, 8'h00);
    wr(`VII_OFF_TYP, 8'h02);
    wr(`VII_OFF_EN, 8'h02);
    wr(`VII_OFF_STAT, 8'hFF);
    din[1] = 1'b1;
    repeat (20) @(negedge clk);
    ack(LVL, {2'b10, vec[1]}, 10'h3FF);
    wr(`VII_OFF_STAT, 8'h02);
    rd(`VII_OFF_STAT, 1'b0, 8'h00);
    din[1] = 1'b0;
    repeat (20) @(negedge clk);
    rd(`VII_OFF_STAT, 1'b1, 8'h02);
    $display("Test change done");
    wr(`VII_OFF_TYP, 8'h00);
    wr(`VII_OFF_POL, 8'hFF);
    wr(`VII_OFF_EN, 8'h18);
    wr(`VII_OFF_STAT, 8'hFF);
    din = 8'h18;
    repeat (20) @(negedge clk);
    ack(LVL, {2'b10, vec[4]}, 10'h3FF);
    $display("Test ties done");
    wr(`VII_OFF_BSR, 8'h00);
    wr(`VII_OFF_EN, 8'h00);
    wr(`VII_OFF_POL, 8'h20);
    wr(`VII_OFF_PEN, 8'h60);
    din = 8'h20;
    wr(`VII_OFF_STAT, 8'hFF);
    rd(`VII_OFF_STAT, 1'b0, 8'h00);
    wr(`VII_OFF_BSR, 8'h08);
    rd(`VII_OFF_BSR, 1'b1, 8'h08);
    rd(`VII_OFF_STAT, 1'b1, 8'h80);
    ack(LVL, {2'b10, vec[7]}, 10'h3FF);
    din = 8'h60;
    repeat (20) @(negedge clk);
    wr(`VII_OFF_STAT, 8'h80);
    rd(`VII_OFF_STAT, 1'b0, 8'h00);
    $display("Test pattern done");
    wr(`VII_OFF_POL, 8'h23);
    wr(`VII_OFF_PEN, 8'h00);
    wr(`VII_OFF_EN, 8'h03);
    deb_sel = 2'b11;
    repeat (4) @(negedge clk);
    din[1:0] = 2'b11;
    rd(`VII_OFF_STAT, 1'b0, 8'h00);
    repeat (150) @(negedge clk);
    rd(`VII_OFF_STAT, 1'b1, 8'h03);
    `CHK("pend out", 8'h03, pend);
    $display("Test debounce done");
    tally_and_finish();
  end
endmodule : vme_input_interrupter_bench
